// >>> logic/prf_framer.sv
`timescale 1ns/1ns
`include "prf_map.svh"
// Overview of operation
// - one to four lanes, all 64b/66b framed
// - 1.28 Gbps lane, divide 2/4/8 or external
// - all active lanes share frame type
// - 66-bit frame, header 01 data, 10 control
// - N data/idle frames then one service frame
// - same service interval on every lane
// - service: code, two addr/value entries, status
// - address msb selects global or pixel row
// - type code B4/55/D2 by entry source, 99 never sent
// - code CC marks error, entries invalid
// - service always filled, per-lane autofill pairs
// - read requests on lane 0 only, priority
// - one pending: second entry; two: both
// - status 1 error, 2 warning, 3 both
// - status 5 trigger full, 6 no lock
// - hit frame carries two four-pixel records
// - header record: 0000001, id, tag, count
// - other records are address plus four charges
// - event headers go as data frames
// - free-running heartbeat of idle and service
// - clock, PRBS-7 or PRBS-31 fixed pattern
// - optional unencoded readout through debug port

module prf_fifo #(
  parameter int WIDTH = 64,
  parameter int DEPTH = 4
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW-1:0] wr_ff, nxt_wr, rd_ff, nxt_rd;
  logic [AW:0] cnt_ff, nxt_cnt;
  logic push, pop;

  assign in_ready = (cnt_ff != DEPTH[AW:0]);
  assign out_valid = (cnt_ff != '0);
  assign out_data = mem_ff[rd_ff];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  always_comb begin
    nxt_wr = push ? wr_ff + 1'b1 : wr_ff;
    nxt_rd = pop ? rd_ff + 1'b1 : rd_ff;
    nxt_cnt = cnt_ff + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      wr_ff <= '0;
      rd_ff <= '0;
      cnt_ff <= '0;
    end else begin
      wr_ff <= nxt_wr;
      rd_ff <= nxt_rd;
      cnt_ff <= nxt_cnt;
    end
  end

  // storage has no reset: contents are never read while empty
  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem_ff[wr_ff] <= in_data;
    end
  end
endmodule

module prf_framer (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic [1:0] cfg_active_lanes,
  input wire logic [1:0] cfg_rate_div,
  input wire logic cfg_ext_clk,
  input wire logic [7:0] cfg_data_frames,
  input wire logic [1:0] cfg_pattern_mode,
  input wire logic cfg_jtag_readout,
  input wire logic [3:0][9:0] autofill_select_first,
  input wire logic [3:0][9:0] autofill_select_second,
  output logic [9:0] reg_lookup_addr,
  input wire logic [15:0] reg_lookup_value,
  input wire logic register_read_request_valid,
  output logic register_read_request_ready,
  input wire prf_pkg::prf_entry_t register_read_request_entry,
  input wire logic err_event,
  input wire logic warn_event,
  input wire logic trig_queue_full,
  input wire logic chan_unlocked,
  input wire logic hit_valid,
  output logic hit_ready,
  input wire logic [63:0] hit_pair,
  input wire logic frame_req,
  output prf_pkg::prf_frame_t [3:0] lane_frame,
  output logic [3:0] lane_enable,
  output logic [2:0] rate_sel,
  output logic jtag_valid,
  input wire logic jtag_ready,
  output logic [63:0] jtag_pair
);
  function automatic logic [3:0] status_code(input logic err, input logic warn,
                                             input logic tfull, input logic unlock);
    if (unlock) begin
      status_code = `PRF_ST_NO_LOCK;
    end else if (tfull) begin
      status_code = `PRF_ST_TRIG_FULL;
    end else if (err && warn) begin
      status_code = `PRF_ST_ERR_WARN;
    end else if (err) begin
      status_code = `PRF_ST_ERROR;
    end else if (warn) begin
      status_code = `PRF_ST_WARN;
    end else begin
      status_code = `PRF_ST_READY;
    end
  endfunction

  // 64 serial steps of x^58+x^39+1; returns {new state, scrambled word}
  function automatic logic [121:0] scramble(input logic [57:0] st, input logic [63:0] d);
    logic [57:0] s;
    logic [63:0] o;
    s = st;
    o = '0;
    for (int i = 63; i >= 0; i--) begin
      o[i] = d[i] ^ s[38] ^ s[57];
      s = {s[56:0], o[i]};
    end
    scramble = {s, o};
  endfunction

  // 66 steps of PRBS-7 (x^7+x^6+1) or PRBS-31 (x^31+x^28+1)
  function automatic logic [96:0] prbs_step(input logic [30:0] st, input logic long_seq);
    logic [30:0] s;
    logic [65:0] o;
    logic fb;
    s = st;
    o = '0;
    for (int i = 65; i >= 0; i--) begin
      fb = long_seq ? (s[30] ^ s[27]) : (s[6] ^ s[5]);
      o[i] = fb;
      s = {s[29:0], fb};
    end
    prbs_step = {s, o};
  endfunction

  // entry with the extended address as given: msb clear = global, set = pixel row
  function automatic prf_pkg::prf_entry_t mk_entry(input logic [9:0] a, input logic [15:0] v);
    mk_entry.addr = a;
    mk_entry.value = v;
  endfunction

  logic [2:0] lanes;
  logic [7:0] nd;
  logic fifo_out_valid, fifo_out_ready;
  logic [63:0] fifo_out_data;
  prf_pkg::prf_pat_t pat;
  prf_pkg::prf_kind_t kind;

  assign lanes = {1'b0, cfg_active_lanes} + 3'h1;
  assign nd = (cfg_data_frames == 8'h00) ? 8'h01 : cfg_data_frames;
  assign pat = prf_pkg::prf_pat_t'(cfg_pattern_mode);

  // records arrive pre-paired into one frame payload; headers and hits look alike here
  prf_fifo #(.WIDTH(64), .DEPTH(`PRF_HIT_FIFO_DEPTH)) u_hit_fifo (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .in_valid(hit_valid),
    .in_ready(hit_ready),
    .in_data(hit_pair),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready),
    .out_data(fifo_out_data)
  );

  // unencoded debug readout takes the stream before framing
  assign jtag_valid = cfg_jtag_readout & fifo_out_valid;
  assign jtag_pair = fifo_out_data;

  // staging: one payload per active lane, a data slot needs every lane filled
  logic [3:0][63:0] stage_ff, nxt_stage;
  logic [2:0] stage_cnt_ff, nxt_stage_cnt;
  logic stage_full;
  assign stage_full = (stage_cnt_ff >= lanes);
  assign fifo_out_ready = cfg_jtag_readout ? jtag_ready : (!stage_full && !frame_req);

  // frame slot scheduling
  logic [7:0] slot_ff, nxt_slot;
  always_comb begin
    nxt_slot = slot_ff;
    kind = prf_pkg::PRF_KIND_IDLE;
    if (slot_ff >= nd) begin
      kind = prf_pkg::PRF_KIND_SVC;
    end else if (stage_full && !cfg_jtag_readout) begin
      kind = prf_pkg::PRF_KIND_DATA;
    end
    if (frame_req && pat == prf_pkg::PRF_PAT_FRAMED) begin
      nxt_slot = (kind == prf_pkg::PRF_KIND_SVC) ? 8'h00 : slot_ff + 8'h01;
    end
  end

  always_comb begin
    nxt_stage = stage_ff;
    nxt_stage_cnt = stage_cnt_ff;
    if (frame_req && kind == prf_pkg::PRF_KIND_DATA && pat == prf_pkg::PRF_PAT_FRAMED) begin
      nxt_stage_cnt = 3'h0;
    end else if (fifo_out_valid && fifo_out_ready && !cfg_jtag_readout) begin
      nxt_stage[stage_cnt_ff[1:0]] = fifo_out_data;
      nxt_stage_cnt = stage_cnt_ff + 3'h1;
    end
  end

  // autofill snapshot: one register looked up per cycle, round robin over eight
  logic [2:0] af_idx_ff, nxt_af_idx;
  logic [7:0][15:0] af_snap_ff, nxt_af_snap;
  assign reg_lookup_addr = af_idx_ff[0] ? autofill_select_second[af_idx_ff[2:1]]
                                        : autofill_select_first[af_idx_ff[2:1]];
  always_comb begin
    nxt_af_idx = af_idx_ff + 3'h1;
    nxt_af_snap = af_snap_ff;
    nxt_af_snap[af_idx_ff] = reg_lookup_value;
  end

  // read request queue, served only on lane 0
  logic [25:0] rdq_mem_ff [`PRF_RDQ_DEPTH];
  logic [1:0] rdq_wr_ff, nxt_rdq_wr, rdq_rd_ff, nxt_rdq_rd;
  logic [2:0] rdq_cnt_ff, nxt_rdq_cnt;
  logic [1:0] rdq_pop_n;
  logic rdq_push, svc_sent;
  assign register_read_request_ready = (rdq_cnt_ff < 3'h4);
  assign rdq_push = register_read_request_valid & register_read_request_ready;
  assign svc_sent = frame_req && kind == prf_pkg::PRF_KIND_SVC
                    && pat == prf_pkg::PRF_PAT_FRAMED;
  always_comb begin
    rdq_pop_n = 2'h0;
    if (svc_sent) begin
      rdq_pop_n = (rdq_cnt_ff >= 3'h2) ? 2'h2 : rdq_cnt_ff[1:0];
    end
    nxt_rdq_wr = rdq_push ? rdq_wr_ff + 2'h1 : rdq_wr_ff;
    nxt_rdq_rd = rdq_rd_ff + rdq_pop_n;
    nxt_rdq_cnt = rdq_cnt_ff + {2'h0, rdq_push} - {1'b0, rdq_pop_n};
  end

  // sticky events since the last service frame; a new event beats the clear
  logic err_ff, warn_ff, ovf_ff, nxt_err, nxt_warn, nxt_ovf;
  always_comb begin
    nxt_err = (err_ff & ~svc_sent) | err_event;
    nxt_warn = (warn_ff & ~svc_sent) | warn_event;
    nxt_ovf = (ovf_ff & ~svc_sent) | (register_read_request_valid & ~register_read_request_ready);
  end

  // service status shared by all lanes; only lane 0 takes the queue code and entries
  prf_pkg::prf_entry_t q_head, q_next;
  logic [3:0] svc_status;
  logic [7:0] svc_code0;
  assign q_head = rdq_mem_ff[rdq_rd_ff];
  assign q_next = rdq_mem_ff[rdq_rd_ff + 2'h1];
  assign svc_status = status_code(err_ff, warn_ff, trig_queue_full, chan_unlocked);
  always_comb begin
    if (ovf_ff) begin
      svc_code0 = `PRF_CODE_ERROR;
    end else if (rdq_cnt_ff >= 3'h2) begin
      svc_code0 = `PRF_CODE_REQ_REQ;
    end else if (rdq_cnt_ff == 3'h1) begin
      svc_code0 = `PRF_CODE_AUTO_REQ;
    end else begin
      svc_code0 = `PRF_CODE_AUTO_AUTO;
    end
  end

  // fixed pattern generator, common to all lanes
  logic [30:0] prbs_ff, nxt_prbs;
  logic [65:0] pat_bits;
  logic [96:0] prbs_res;
  always_comb begin
    prbs_res = prbs_step(prbs_ff, pat == prf_pkg::PRF_PAT_PRBS31);
    nxt_prbs = prbs_ff;
    pat_bits = `PRF_CLOCK_PATTERN;
    if (pat == prf_pkg::PRF_PAT_PRBS7 || pat == prf_pkg::PRF_PAT_PRBS31) begin
      pat_bits = prbs_res[65:0];
      if (frame_req) begin
        nxt_prbs = prbs_res[96:66];
      end
    end
  end

  // clock-recovery unit rate select: {external, divider code}
  logic [2:0] rate_ff, nxt_rate;
  assign nxt_rate = {cfg_ext_clk, cfg_rate_div};
  assign rate_sel = rate_ff;

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      slot_ff <= 8'h00;
      stage_ff <= '0;
      stage_cnt_ff <= 3'h0;
      af_idx_ff <= 3'h0;
      af_snap_ff <= '0;
      rdq_wr_ff <= 2'h0;
      rdq_rd_ff <= 2'h0;
      rdq_cnt_ff <= 3'h0;
      err_ff <= 1'b0;
      warn_ff <= 1'b0;
      ovf_ff <= 1'b0;
      prbs_ff <= `PRF_PRBS_SEED;
      rate_ff <= 3'h0;
    end else begin
      slot_ff <= nxt_slot;
      stage_ff <= nxt_stage;
      stage_cnt_ff <= nxt_stage_cnt;
      af_idx_ff <= nxt_af_idx;
      af_snap_ff <= nxt_af_snap;
      rdq_wr_ff <= nxt_rdq_wr;
      rdq_rd_ff <= nxt_rdq_rd;
      rdq_cnt_ff <= nxt_rdq_cnt;
      err_ff <= nxt_err;
      warn_ff <= nxt_warn;
      ovf_ff <= nxt_ovf;
      prbs_ff <= nxt_prbs;
      rate_ff <= nxt_rate;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rdq_push) begin
      rdq_mem_ff[rdq_wr_ff] <= register_read_request_entry;
    end
  end

  // per-lane framing and scrambling; one shared kind keeps lanes aligned
  for (genvar l = 0; l < `PRF_LANES; l++) begin : g_lane
    logic [57:0] scr_ff, nxt_scr;
    prf_pkg::prf_frame_t frm_ff, nxt_frm;
    logic en_ff, nxt_en;
    prf_pkg::prf_entry_t ent_a, ent_b;
    logic [7:0] code;
    logic [63:0] plain;
    logic [121:0] scr_res;
    logic active;

    assign active = (l < lanes);

    always_comb begin
      ent_a = mk_entry(autofill_select_first[l], af_snap_ff[2*l]);
      ent_b = mk_entry(autofill_select_second[l], af_snap_ff[2*l+1]);
      code = `PRF_CODE_AUTO_AUTO;
      if (l == 0) begin
        code = svc_code0;
        if (rdq_cnt_ff >= 3'h2) begin
          ent_a = q_head;
          ent_b = q_next;
        end else if (rdq_cnt_ff == 3'h1) begin
          ent_b = q_head;
        end
      end
      case (kind)
        prf_pkg::PRF_KIND_SVC: plain = {code, ent_a, ent_b, svc_status};
        prf_pkg::PRF_KIND_DATA: plain = stage_ff[l];
        default: plain = {`PRF_CODE_IDLE, 56'h00_0000_0000_0000};
      endcase
      scr_res = scramble(scr_ff, plain);
      nxt_scr = scr_ff;
      nxt_frm = frm_ff;
      nxt_en = frame_req ? active : en_ff;
      if (frame_req) begin
        if (!active) begin
          nxt_frm = '0;
        end else if (pat != prf_pkg::PRF_PAT_FRAMED) begin
          nxt_frm = pat_bits;
        end else begin
          nxt_frm.sync = (kind == prf_pkg::PRF_KIND_DATA) ? `PRF_HDR_DATA : `PRF_HDR_CTRL;
          nxt_frm.payload = scr_res[63:0];
          nxt_scr = scr_res[121:64];
        end
      end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
        scr_ff <= `PRF_SCR_SEED;
        frm_ff <= '0;
        en_ff <= 1'b0;
      end else begin
        scr_ff <= nxt_scr;
        frm_ff <= nxt_frm;
        en_ff <= nxt_en;
      end
    end

    assign lane_frame[l] = frm_ff;
    assign lane_enable[l] = en_ff;
  end
endmodule

// >>> logic/prf_map.svh
`ifndef PRF_MAP_SVH
`define PRF_MAP_SVH
`define PRF_LANES 4
`define PRF_LANE_RATE_MBPS 1280
`define PRF_RATE_DIV_MAX 8
`define PRF_HDR_DATA 2'h1
`define PRF_HDR_CTRL 2'h2
`define PRF_CODE_AUTO_AUTO 8'hb4
`define PRF_CODE_AUTO_REQ 8'h55
`define PRF_CODE_REQ_AUTO 8'h99
`define PRF_CODE_REQ_REQ 8'hd2
`define PRF_CODE_ERROR 8'hcc
`define PRF_CODE_IDLE 8'h78
`define PRF_ST_READY 4'h0
`define PRF_ST_ERROR 4'h1
`define PRF_ST_WARN 4'h2
`define PRF_ST_ERR_WARN 4'h3
`define PRF_ST_TRIG_FULL 4'h5
`define PRF_ST_NO_LOCK 4'h6
`define PRF_HEADER_MARK 7'h01
`define PRF_SCR_SEED 58'h3ff_ffff_ffff_ffff
`define PRF_PRBS_SEED 31'h7fff_ffff
`define PRF_CLOCK_PATTERN 66'h2_aaaa_aaaa_aaaa_aaaa
`define PRF_RDQ_DEPTH 4
`define PRF_HIT_FIFO_DEPTH 4
`endif

// >>> logic/prf_pkg.sv
package prf_pkg;
  typedef enum logic [1:0] {
    PRF_PAT_FRAMED = 2'h0,
    PRF_PAT_CLOCK = 2'h1,
    PRF_PAT_PRBS7 = 2'h2,
    PRF_PAT_PRBS31 = 2'h3
  } prf_pat_t;
  typedef enum logic [1:0] {
    PRF_KIND_IDLE = 2'h0,
    PRF_KIND_DATA = 2'h1,
    PRF_KIND_SVC = 2'h2
  } prf_kind_t;
  typedef struct packed {
    logic [9:0] addr;
    logic [15:0] value;
  } prf_entry_t;
  typedef struct packed {
    logic [1:0] sync;
    logic [63:0] payload;
  } prf_frame_t;
  typedef struct packed {
    logic [6:0] mark;
    logic [4:0] trig_id;
    logic [4:0] trig_tag;
    logic [14:0] bunch_crossing_count;
  } prf_event_header_t;
  typedef struct packed {
    logic [15:0] pix_addr;
    logic [3:0][3:0] charge;
  } prf_hit_rec_t;
endpackage

// >>> verif/prf_framer_properties.sv
`timescale 1ns/1ns
`include "prf_map.svh"
module prf_framer_properties (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic [1:0] cfg_active_lanes,
  input wire logic [1:0] cfg_rate_div,
  input wire logic cfg_ext_clk,
  input wire logic [7:0] cfg_data_frames,
  input wire logic [1:0] cfg_pattern_mode,
  input wire logic frame_req,
  input wire prf_pkg::prf_frame_t [3:0] lane_frame,
  input wire logic [3:0] lane_enable,
  input wire logic [2:0] rate_sel,
  input wire logic jtag_valid,
  input wire logic jtag_ready,
  input wire logic [63:0] jtag_pair
);
  logic [1:0] mode_ff;
  logic upd_ff;
  logic [7:0] gap_ff;
  logic [7:0] nf;
  logic [3:0] lane_mask;
  logic [57:0] dsc_ff, nxt_dsc;
  logic [63:0] plain0;
  logic is_svc;
  assign nf = (cfg_data_frames == 8'h00) ? 8'h01 : cfg_data_frames;
  assign lane_mask = 4'hf >> (2'h3 - cfg_active_lanes);
  // idle frames are control frames too, so lane 0 (always active) is descrambled here
  always_comb begin
    nxt_dsc = dsc_ff;
    plain0 = '0;
    for (int b = 63; b >= 0; b--) begin
      plain0[b] = lane_frame[0].payload[b] ^ nxt_dsc[38] ^ nxt_dsc[57];
      nxt_dsc = {nxt_dsc[56:0], lane_frame[0].payload[b]};
    end
  end
  assign is_svc = (lane_frame[0].sync == 2'h2) && (plain0[63:56] != `PRF_CODE_IDLE);
  // gap counts framed slots since the last service frame; pattern slots freeze it
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      mode_ff <= 2'h0;
      upd_ff <= 1'b0;
      gap_ff <= 8'h00;
      dsc_ff <= `PRF_SCR_SEED;
    end else begin
      upd_ff <= frame_req;
      if (frame_req) begin
        mode_ff <= cfg_pattern_mode;
      end
      if (upd_ff && mode_ff == 2'h0) begin
        gap_ff <= is_svc ? 8'h00 : gap_ff + 8'h01;
        dsc_ff <= nxt_dsc;
      end
    end
  end
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!nrst);
  sequence s_stall;
    jtag_valid && !jtag_ready;
  endsequence
  sequence s_framed;
    upd_ff && mode_ff == 2'h0;
  endsequence
  a_rate_follow: assert property (nrst |=> rate_sel == $past({cfg_ext_clk, cfg_rate_div}))
    else $error("rate select lags config");
  a_lane_count: assert property (frame_req |=> lane_enable == $past(lane_mask))
    else $error("lane enables wrong");
  a_lane_off: assert property (!lane_enable[3] |-> lane_frame[3] == '0)
    else $error("inactive lane not quiet");
  a_frame_hold: assert property (!frame_req |=> $stable(lane_frame))
    else $error("frame changed between slots");
  a_sync_legal: assert property (s_framed ##0 lane_enable[0] |->
    lane_frame[0].sync inside {2'h1, 2'h2})
    else $error("illegal sync header");
  a_strict_align: assert property (s_framed |->
    (!lane_enable[1] || lane_frame[1].sync == lane_frame[0].sync) &&
    (!lane_enable[2] || lane_frame[2].sync == lane_frame[0].sync) &&
    (!lane_enable[3] || lane_frame[3].sync == lane_frame[0].sync))
    else $error("lanes carry different frame types");
  a_service_slot: assert property (s_framed ##0 lane_enable[0] |->
    is_svc == (gap_ff == nf))
    else $error("service frame outside its slot");
  a_jtag_hold: assert property (s_stall |=> jtag_valid && $stable(jtag_pair))
    else $error("debug word dropped while stalled");
endmodule
bind prf_framer prf_framer_properties u_props (
  .sys_clk, .nrst, .cfg_active_lanes, .cfg_rate_div, .cfg_ext_clk, .cfg_data_frames,
  .cfg_pattern_mode, .frame_req, .lane_frame, .lane_enable, .rate_sel, .jtag_valid,
  .jtag_ready, .jtag_pair
);

// >>> verif/prf_rx_model.sv
`timescale 1ns/1ns
`include "prf_map.svh"
module prf_rx_model (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire prf_pkg::prf_frame_t [3:0] lane_frame,
  input wire logic [3:0] lane_enable,
  output logic frame_req,
  output logic rx_valid,
  output logic [3:0][1:0] rx_sync,
  output logic [3:0][63:0] rx_pay
);
  logic [1:0] cnt_ff;
  logic take_ff;
  logic [3:0][57:0] scr_ff;
  always @(posedge sys_clk or negedge nrst) begin : rx
    logic [57:0] s;
    logic [63:0] d;
    if (!nrst) begin
      cnt_ff <= 2'h0;
      frame_req <= 1'b0;
      take_ff <= 1'b0;
      rx_valid <= 1'b0;
      rx_sync <= '0;
      rx_pay <= '0;
      scr_ff <= {4{`PRF_SCR_SEED}};
    end else begin
      cnt_ff <= cnt_ff + 2'h1;
      // one slot in four cycles leaves idle cycles for hit staging
      frame_req <= (cnt_ff == 2'h3);
      take_ff <= frame_req;
      rx_valid <= take_ff;
      if (take_ff) begin
        for (int l = 0; l < 4; l++) begin
          s = scr_ff[l];
          for (int b = 63; b >= 0; b--) begin
            d[b] = lane_frame[l].payload[b] ^ s[38] ^ s[57];
            s = {s[56:0], lane_frame[l].payload[b]};
          end
          rx_sync[l] <= lane_frame[l].sync;
          rx_pay[l] <= d;
          if (lane_enable[l]) begin
            scr_ff[l] <= s;
          end
        end
      end
    end
  end
endmodule

// >>> verif/testbench.sv
`timescale 1ns/1ns
`include "prf_map.svh"
module testbench;
  localparam logic [63:0] W0 = {7'h01, 5'h03, 5'h11, 15'h1abc, 32'h0123_4567};
  localparam logic [63:0] W1 = 64'h0a0b_c1d2_0e0f_9876;
  localparam logic [7:0] ST_TAB [6] = '{8'h81, 8'h42, 8'hc3, 8'h25, 8'h16, 8'h36};
  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  logic [1:0] cfg_active_lanes = 2'h1;
  logic [1:0] cfg_rate_div = 2'h0;
  logic cfg_ext_clk = 1'b0;
  logic [7:0] cfg_data_frames = 8'h03;
  logic [1:0] cfg_pattern_mode = 2'h0;
  logic cfg_jtag_readout = 1'b0;
  logic [3:0][9:0] autofill_select_first = {10'h013, 10'h012, 10'h011, 10'h010};
  logic [3:0][9:0] autofill_select_second = {10'h123, 10'h122, 10'h121, 10'h120};
  logic [9:0] reg_lookup_addr;
  logic [15:0] reg_lookup_value;
  logic register_read_request_valid = 1'b0;
  logic register_read_request_ready;
  prf_pkg::prf_entry_t register_read_request_entry = '0;
  logic err_event = 1'b0;
  logic warn_event = 1'b0;
  logic trig_queue_full = 1'b0;
  logic chan_unlocked = 1'b0;
  logic hit_valid = 1'b0;
  logic hit_ready;
  logic [63:0] hit_pair = '0;
  logic frame_req;
  prf_pkg::prf_frame_t [3:0] lane_frame;
  logic [3:0] lane_enable;
  logic [2:0] rate_sel;
  logic jtag_valid;
  logic jtag_ready = 1'b0;
  logic [63:0] jtag_pair;
  logic rx_valid;
  logic [3:0][1:0] rx_sync;
  logic [3:0][63:0] rx_pay;
  int num_errors = 0;
  int n_tests = 0;
  int cycles = 0;
  // register file stand-in answers in the same cycle with a value derived from the address
  assign reg_lookup_value = {6'h2a, reg_lookup_addr};
  prf_framer u_dut (
    .sys_clk, .nrst, .cfg_active_lanes, .cfg_rate_div, .cfg_ext_clk, .cfg_data_frames,
    .cfg_pattern_mode, .cfg_jtag_readout, .autofill_select_first, .autofill_select_second,
    .reg_lookup_addr, .reg_lookup_value, .register_read_request_valid,
    .register_read_request_ready, .register_read_request_entry, .err_event, .warn_event,
    .trig_queue_full, .chan_unlocked, .hit_valid, .hit_ready, .hit_pair, .frame_req,
    .lane_frame, .lane_enable, .rate_sel, .jtag_valid, .jtag_ready, .jtag_pair
  );
  prf_rx_model u_rx (
    .sys_clk, .nrst, .lane_frame, .lane_enable, .frame_req, .rx_valid, .rx_sync, .rx_pay
  );
  function automatic logic [25:0] av(input logic [9:0] x);
    return {x, 6'h2a, x};
  endfunction
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [65:0] exp, input logic [65:0] got);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic get_frame(input logic svc, input logic any);
    for (int i = 0; i < 200; i++) begin
      @(posedge sys_clk);
      if (rx_valid === 1'b1 && (any || (svc ? (rx_sync[0] == 2'h2 &&
          rx_pay[0][63:56] != `PRF_CODE_IDLE) : rx_sync[0] == 2'h1))) return;
    end
    chk("frame wait", 66'h1, 66'h0);
  endtask
  task automatic push_req(input logic [25:0] e);
    @(negedge sys_clk);
    register_read_request_entry = e;
    register_read_request_valid = 1'b1;
    for (int i = 0; i < 2; i++) begin
      @(posedge sys_clk);
      if (register_read_request_ready === 1'b1) break;
    end
    @(negedge sys_clk);
    register_read_request_valid = 1'b0;
  endtask
  task automatic push_hit(input logic [63:0] w, output logic ok);
    @(negedge sys_clk);
    hit_pair = w;
    hit_valid = 1'b1;
    ok = 1'b0;
    for (int i = 0; i < 4 && !ok; i++) begin
      @(posedge sys_clk);
      ok = (hit_ready === 1'b1);
    end
    @(negedge sys_clk);
    hit_valid = 1'b0;
  endtask
  initial begin
    forever #50 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      complete_run();
    end
  end
  initial begin
    logic ok;
    int n;
    repeat (12) @(posedge sys_clk);
    @(negedge sys_clk);
    nrst = 1'b1;
    get_frame(1'b0, 1'b1);
    chk("idle", {2'h2, 8'h78, 56'h0}, {rx_sync[0], rx_pay[0]});
    get_frame(1'b1, 1'b0);
    chk("beat0", {2'h2, 8'hb4, av(10'h010), av(10'h120), 4'h0}, {rx_sync[0], rx_pay[0]});
    chk("beat1", {2'h2, 8'hb4, av(10'h011), av(10'h121), 4'h0}, {rx_sync[1], rx_pay[1]});
    $display("test heartbeat done");
    push_req({10'h205, 16'h1234});
    get_frame(1'b1, 1'b0);
    chk("one0", {2'h2, 8'h55, av(10'h010), 26'h205_1234, 4'h0}, {rx_sync[0], rx_pay[0]});
    chk("one1", {2'h2, 8'hb4, av(10'h011), av(10'h121), 4'h0}, {rx_sync[1], rx_pay[1]});
    push_req({10'h011, 16'h0abc});
    push_req({10'h102, 16'hbeef});
    get_frame(1'b1, 1'b0);
    chk("two0", {2'h2, 8'hd2, 26'h011_0abc, 26'h102_beef, 4'h0}, {rx_sync[0], rx_pay[0]});
    $display("test read requests done");
    for (int i = 0; i < 6; i++) begin
      @(negedge sys_clk);
      {err_event, warn_event, trig_queue_full, chan_unlocked} = ST_TAB[i][7:4];
      @(negedge sys_clk);
      err_event = 1'b0;
      warn_event = 1'b0;
      get_frame(1'b1, 1'b0);
      chk("status", {62'h0, ST_TAB[i][3:0]}, {62'h0, rx_pay[0][3:0]});
    end
    @(negedge sys_clk);
    {trig_queue_full, chan_unlocked} = 2'h0;
    $display("test status done");
    // fifth push overflows the queue on purpose
    for (int i = 0; i < 5; i++) push_req({10'h030, 16'(i)});
    chk("full", 66'h0, {65'h0, register_read_request_ready});
    get_frame(1'b1, 1'b0);
    chk("overflow", {58'h0, 8'hcc}, {58'h0, rx_pay[0][63:56]});
    $display("test overflow done");
    push_hit(W0, ok);
    push_hit(W1, ok);
    for (int i = 0; i < 8 && rx_pay[0] !== W0; i++) get_frame(1'b0, 1'b0);
    chk("hit0", {2'h1, W0}, {rx_sync[0], rx_pay[0]});
    chk("hit1", {2'h1, W1}, {rx_sync[1], rx_pay[1]});
    $display("test hit data done");
    @(negedge sys_clk);
    cfg_jtag_readout = 1'b1;
    n = 0;
    for (int i = 0; i < 6; i++) begin
      push_hit({4{16'h00a0 + 16'(i)}}, ok);
      if (ok) n++;
    end
    chk("fill", 66'h4, 66'(n));
    @(negedge sys_clk);
    jtag_ready = 1'b1;
    for (int i = 0; i < 4; i++) begin
      @(posedge sys_clk);
      chk("drain", {2'h1, {4{16'h00a0 + 16'(i)}}}, {1'b0, jtag_valid, jtag_pair});
    end
    @(posedge sys_clk);
    chk("empty", 66'h0, {65'h0, jtag_valid});
    @(negedge sys_clk);
    jtag_ready = 1'b0;
    cfg_jtag_readout = 1'b0;
    $display("test debug readout done");
    for (int i = 0; i < 8; i++) begin
      @(negedge sys_clk);
      {cfg_ext_clk, cfg_rate_div} = 3'(i);
      repeat (2) @(posedge sys_clk);
      chk("rate", {63'h0, 3'(i)}, {63'h0, rate_sel});
    end
    $display("test rate done");
    for (int i = 1; i < 4; i++) begin
      @(negedge sys_clk);
      cfg_pattern_mode = 2'(i);
      get_frame(1'b0, 1'b1);
      get_frame(1'b0, 1'b1);
      chk("pattern align", lane_frame[0], lane_frame[1]);
      if (i == 1) chk("clock", `PRF_CLOCK_PATTERN, lane_frame[0]);
    end
    @(negedge sys_clk);
    cfg_pattern_mode = 2'h0;
    $display("test patterns done");
    for (int i = 0; i < 4; i++) begin
      @(negedge sys_clk);
      cfg_active_lanes = 2'(i);
      get_frame(1'b0, 1'b1);
      get_frame(1'b0, 1'b1);
      chk("lanes", {62'h0, 4'hf >> (3 - i)}, {62'h0, lane_enable});
    end
    $display("test lanes done");
    complete_run();
  end
endmodule
